// ---- hw/sadcc_pkg.sv ----
// package: constants for the sar converter control block
package sadcc_pkg;
  localparam int unsigned NUM_INPUTS      = 10;
  localparam int unsigned SEL_W           = 4;
  localparam int unsigned RES_W           = 12;
  localparam int unsigned LO_RES_W        = 8;
  localparam int unsigned DIV_W           = 3;
  localparam int unsigned STEP_W          = 5;
  localparam int unsigned PRE_W           = 5;
  localparam logic [STEP_W-1:0] STEPS_8B  = 5'h0c;
  localparam logic [STEP_W-1:0] STEPS_12B = 5'h10;
  localparam logic [1:0] CLK_PER_STEP_M1  = 2'h3;
  localparam logic [DIV_W-1:0] DIV_MAX_CODE = 3'h5;
  localparam logic [SEL_W-1:0] SEL_MAX    = 4'h9;
  localparam logic RES_8B                 = 1'b0;
  localparam logic RES_12B                = 1'b1;
  localparam logic REF_INTERNAL           = 1'b0;
  localparam logic REF_EXTERNAL           = 1'b1;
  typedef enum logic [2:0] {
    SADCC_IDLE = 3'b001,
    SADCC_CONV = 3'b010,
    SADCC_DONE = 3'b100
  } sadcc_state_type;
endpackage

// ---- hw/sadcc_clkdiv.sv ----
// converter clock divider: one-cycle enable per divided converter clock
`timescale 1ns/1ps
`default_nettype none
module sadcc_clkdiv
  import sadcc_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] div_sel,
  output logic                  tick
);
  logic [PRE_W-1:0] cnt_ff;
  logic [PRE_W-1:0] limit;

  // codes above the largest legal one fall back to the slowest rate
  always_comb begin
    if (div_sel > DIV_MAX_CODE) begin
      limit = (PRE_W)'((1 << DIV_MAX_CODE) - 1);
    end else begin
      limit = (PRE_W)'((1 << div_sel) - 1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (!run || cnt_ff >= limit) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign tick = run && (cnt_ff >= limit);

  a_tick_period : assert property (@(posedge sys_clk) disable iff (!rst_n)
    (tick && div_sel == 3'h1 && $stable(div_sel) && run) |=>
      (!tick || !run || !$stable(div_sel)))
    else $error("divide by 2 ticked twice in a row");
endmodule
`default_nettype wire

// ---- hw/sadcc_top.sv ----
// sar converter control: sequencing, step timing, result and flags
`timescale 1ns/1ps
`default_nettype none
// Function
// - pick one of ten inputs 0..9 with a four-bit select
// - start only with global channel enable and go both set
// - on finish set done flag and load result buffer
// - resolution bit: zero is 8-bit, one is 12-bit
// - 12 steps at 8-bit, 16 steps at 12-bit
// - each step lasts four converter clock periods
// - converter clock is peripheral clock divided by 1..32 per code
// - duration runs from go rising to done rising
// - hardware clears go when conversion finishes
// - done reads zero while converting, cleared when go set
// - reference select: zero internal supply, one external pin
// - finish also sets irq flag; request raised when enabled
// - 8-bit result in upper eight bits of twelve-bit field
// - writing zero to go stops a running conversion
module sadcc_top
  import sadcc_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             converter_enable,
  input  wire logic             high_ref_source_select,
  input  wire logic             resolution_select,
  input  wire logic [DIV_W-1:0] converter_clock_divider,
  input  wire logic             global_channel_enable,
  input  wire logic [SEL_W-1:0] input_select,
  input  wire logic             go_set,
  input  wire logic             go_clear,
  input  wire logic             irq_enable,
  input  wire logic             irq_flag_clear,
  input  wire logic [RES_W-1:0] sar_data,
  output logic                  convert_go,
  output logic                  conversion_done,
  output logic                  conversion_irq_flag,
  output logic                  irq_request,
  output logic [RES_W-1:0]      result_buffer,
  output logic [NUM_INPUTS-1:0] analog_inputs_select,
  output logic                  channel_connect,
  output logic                  ext_ref_enable,
  output logic                  sample_strobe,
  output logic                  core_power
);
  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire logic rs_n = rst_sync_ff;

  // ************************************************************
  // sequencer
  // ************************************************************
  sadcc_state_type state_ff;
  sadcc_state_type nxt_state;
  logic             go_ff;
  logic             done_ff;
  logic             irq_ff;
  logic [STEP_W-1:0] step_ff;
  logic [1:0]       sub_ff;
  logic             res_ff;
  logic             tick;
  logic             start_req;
  logic             finish;
  logic [STEP_W-1:0] step_last;

  // a go request without enables is dropped, never held pending
  assign start_req = go_set && converter_enable
                     && global_channel_enable;
  assign step_last = (res_ff == RES_12B) ? STEPS_12B - 1'b1
                                         : STEPS_8B - 1'b1;
  assign finish = (state_ff == SADCC_CONV) && tick
                  && (sub_ff == CLK_PER_STEP_M1)
                  && (step_ff == step_last)
                  && !go_clear && converter_enable;

  sadcc_clkdiv u_div (
    .sys_clk (sys_clk),
    .rst_n   (rs_n),
    .run     (state_ff == SADCC_CONV && converter_enable),
    .div_sel (converter_clock_divider),
    .tick    (tick)
  );

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SADCC_IDLE, SADCC_DONE: begin
        if (start_req) begin
          nxt_state = SADCC_CONV;
        end
      end
      SADCC_CONV: begin
        if (go_clear || !global_channel_enable) begin
          nxt_state = SADCC_IDLE;
        end else if (finish) begin
          nxt_state = SADCC_DONE;
        end
      end
      default: nxt_state = SADCC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rs_n) begin
    if (!rs_n) begin
      state_ff <= SADCC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // resolution is latched at start so a mid-run change cannot skew steps
  always_ff @(posedge sys_clk or negedge rs_n) begin
    if (!rs_n) begin
      res_ff <= RES_8B;
    end else if (start_req && state_ff != SADCC_CONV) begin
      res_ff <= resolution_select;
    end
  end

  // step counting frozen while disabled
  always_ff @(posedge sys_clk or negedge rs_n) begin
    if (!rs_n) begin
      step_ff <= '0;
      sub_ff  <= '0;
    end else if (state_ff != SADCC_CONV) begin
      step_ff <= '0;
      sub_ff  <= '0;
    end else if (tick && converter_enable) begin
      sub_ff <= sub_ff + 1'b1;
      if (sub_ff == CLK_PER_STEP_M1) begin
        step_ff <= step_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rs_n) begin
    if (!rs_n) begin
      go_ff <= 1'b0;
    end else if (start_req && state_ff != SADCC_CONV) begin
      go_ff <= 1'b1;
    end else if (finish || go_clear
                 || (state_ff == SADCC_CONV && !global_channel_enable)) begin
      go_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rs_n) begin
    if (!rs_n) begin
      done_ff <= 1'b0;
    end else if (finish) begin
      done_ff <= 1'b1;
    end else if (start_req) begin
      done_ff <= 1'b0;
    end
  end

  // set wins over software clear
  always_ff @(posedge sys_clk or negedge rs_n) begin
    if (!rs_n) begin
      irq_ff <= 1'b0;
    end else if (finish) begin
      irq_ff <= 1'b1;
    end else if (irq_flag_clear) begin
      irq_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rs_n) begin
    if (!rs_n) begin
      result_buffer <= '0;
    end else if (finish) begin
      if (res_ff == RES_12B) begin
        result_buffer <= sar_data;
      end else begin
        result_buffer <= {sar_data[RES_W-1:RES_W-LO_RES_W],
                          (RES_W-LO_RES_W)'(0)};
      end
    end
  end

  // ************************************************************
  // analog front-end controls
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_sel
      // codes above nine select nothing
      assign analog_inputs_select[gi] = global_channel_enable
        && (input_select == SEL_W'(gi));
    end
  endgenerate

  assign channel_connect = global_channel_enable
                           && (input_select <= SEL_MAX);
  assign ext_ref_enable  = high_ref_source_select == REF_EXTERNAL;
  assign core_power      = converter_enable;
  assign sample_strobe   = (state_ff == SADCC_CONV) && tick
                           && (sub_ff == CLK_PER_STEP_M1);
  assign convert_go      = go_ff;
  assign conversion_done = done_ff;
  assign conversion_irq_flag = irq_ff;
  assign irq_request     = irq_ff && irq_enable;

  // ************************************************************
  // checks
  // ************************************************************
  // converting cycles while enabled; frozen cycles add nothing, and a
  // counter keeps the long length check cheap to evaluate
  logic [STEP_W+PRE_W+1:0] len_ff;
  always_ff @(posedge sys_clk or negedge rs_n) begin
    if (!rs_n) begin
      len_ff <= '0;
    end else if (state_ff != SADCC_CONV) begin
      len_ff <= '0;
    end else if (converter_enable) begin
      len_ff <= len_ff + 1'b1;
    end
  end

  sequence s_finish;
    finish;
  endsequence

  sequence s_start;
    start_req && state_ff != SADCC_CONV;
  endsequence

  // at divide-by-1 every enabled converting cycle is a converter tick
  sequence s_fast_finish;
    finish && converter_clock_divider == '0;
  endsequence

  a_done_on_finish : assert property (@(posedge sys_clk) disable iff (!rs_n)
    s_finish |=> (done_ff && irq_ff && !go_ff))
    else $error("finish did not set done and clear go");
  a_done_clear_go : assert property (@(posedge sys_clk) disable iff (!rs_n)
    (start_req && !finish) |=> !done_ff)
    else $error("done not cleared by start");
  a_no_start_off : assert property (@(posedge sys_clk) disable iff (!rs_n)
    (state_ff != SADCC_CONV && !converter_enable) |=>
      state_ff != SADCC_CONV)
    else $error("conversion started while disabled");
  a_stop_on_zero : assert property (@(posedge sys_clk) disable iff (!rs_n)
    (state_ff == SADCC_CONV && go_clear) |=>
      (state_ff == SADCC_IDLE && !go_ff && !done_ff))
    else $error("go clear did not stop conversion");
  a_step_count : assert property (@(posedge sys_clk) disable iff (!rs_n)
    finish |-> ((res_ff && step_ff == 5'h0f)
                || (!res_ff && step_ff == 5'h0b)))
    else $error("wrong step count at finish");
  a_result_8b : assert property (@(posedge sys_clk) disable iff (!rs_n)
    (finish && !res_ff) |=> result_buffer[3:0] == 4'h0)
    else $error("8-bit result low bits not zero");
  // length check only holds while the divider code stays put mid-run
  a_fast_length : assert property (
    @(posedge sys_clk) disable iff (!rs_n)
    s_fast_finish |-> len_ff == {step_last, CLK_PER_STEP_M1})
    else $error("divide-by-1 conversion length wrong");
  a_irq_out : assert property (
    @(posedge sys_clk) disable iff (!rs_n)
    s_finish ##1 irq_enable |-> irq_request)
    else $error("irq request missing after finish");

  // finish and a software clear in one cycle: the set must survive
  a_irq_set_wins : assert property (
    @(posedge sys_clk) disable iff (!rs_n)
    (finish && irq_flag_clear) |=> irq_ff)
    else $error("irq flag lost to clear at finish");
  a_irq_clear : assert property (
    @(posedge sys_clk) disable iff (!rs_n)
    (irq_flag_clear && !finish) |=> !irq_ff)
    else $error("irq flag not cleared");
  a_go_rise : assert property (
    @(posedge sys_clk) disable iff (!rs_n)
    s_start |=> (go_ff && state_ff == SADCC_CONV))
    else $error("accepted start did not raise go");
  // losing the global enable mid-run must not leave a half conversion
  a_gce_abort : assert property (
    @(posedge sys_clk) disable iff (!rs_n)
    (state_ff == SADCC_CONV && !global_channel_enable) |=>
      (state_ff == SADCC_IDLE && !go_ff))
    else $error("global enable drop did not abort");
  // a disabled core keeps its place so the run resumes where it stopped
  a_steps_frozen : assert property (
    @(posedge sys_clk) disable iff (!rs_n)
    (state_ff == SADCC_CONV && !converter_enable) |=>
      ($stable(step_ff) && $stable(sub_ff)))
    else $error("step counter moved while disabled");
  a_go_hold : assert property (@(posedge sys_clk) disable iff (!rs_n)
    (go_ff && state_ff == SADCC_CONV && !finish && !go_clear
     && global_channel_enable) |=> go_ff)
    else $error("go dropped early");
endmodule
`default_nettype wire

// ---- sim/sadcc_sar_model.sv ----
// sar core model: per-input code when selected, moving junk otherwise
`timescale 1ns/1ps
`default_nettype none
module sadcc_sar_model
  import sadcc_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  core_power,
  input  wire logic                  channel_connect,
  input  wire logic [NUM_INPUTS-1:0] analog_inputs_select,
  input  wire logic                  ext_ref_enable,
  input  wire logic [RES_W-1:0]      level,
  output logic      [RES_W-1:0]      sar_data
);
  logic [RES_W-1:0] noise_ff = 12'h0c3;
  logic [RES_W-1:0] code;
  int               hits;
  // junk changes every cycle so a stale value can never look right
  always @(posedge sys_clk) noise_ff <= noise_ff + 12'h3a5;
  always_comb begin
    code = 12'h000;
    hits = 0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (analog_inputs_select[i]) begin
        code = 12'(i);
        hits++;
      end
    end
  end
  // answers only for one powered, connected input
  assign sar_data = (core_power && channel_connect && hits == 1) ?
                    (level ^ code ^ {ext_ref_enable, 11'h000}) : noise_ff;
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for the sar converter control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
  import sadcc_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, en = 1'b0, xref = 1'b0, res = 1'b0;
  logic gce = 1'b0, go_set = 1'b0, go_clear = 1'b0, ie = 1'b0, ic = 1'b0;
  logic [DIV_W-1:0] div = 3'h0;
  logic [SEL_W-1:0] sel = 4'h0;
  logic [RES_W-1:0] level = 12'h000, sar_data, result_buffer;
  logic [NUM_INPUTS-1:0] ain;
  logic go, done, flag, irq, conn, ext, strobe, pwr;
  logic [15:0] lfsr = 16'hba10;
  logic [15:0] v;
  int fails = 0, check_count = 0, cycles = 0, strobes = 0;
  sadcc_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .converter_enable(en),
    .high_ref_source_select(xref), .resolution_select(res),
    .converter_clock_divider(div), .global_channel_enable(gce),
    .input_select(sel), .go_set(go_set), .go_clear(go_clear),
    .irq_enable(ie), .irq_flag_clear(ic), .sar_data(sar_data),
    .convert_go(go), .conversion_done(done), .conversion_irq_flag(flag),
    .irq_request(irq), .result_buffer(result_buffer),
    .analog_inputs_select(ain), .channel_connect(conn),
    .ext_ref_enable(ext), .sample_strobe(strobe), .core_power(pwr));
  sadcc_sar_model core (.sys_clk(sys_clk), .core_power(pwr),
    .channel_connect(conn), .analog_inputs_select(ain),
    .ext_ref_enable(ext), .level(level), .sar_data(sar_data));
  function automatic logic [RES_W-1:0] exp_res(input logic [RES_W-1:0] l,
      input logic [SEL_W-1:0] s, input logic r, input logic x);
    logic [RES_W-1:0] raw;
    raw = l ^ {8'h00, s} ^ {x, 11'h000};
    return r ? raw : {raw[11:4], 4'h0};
  endfunction
  function automatic int exp_len(input logic [2:0] d, input logic r);
    return (r ? 16 : 12) * 4 * (1 << (d > 3'h5 ? 5 : d));
  endfunction
  task automatic rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    v = lfsr;
  endtask
  // one-cycle strobe: bit 0 go_set, bit 1 go_clear
  task automatic pulse(input logic [1:0] m);
    @(posedge sys_clk) {go_clear, go_set} <= m;
    @(posedge sys_clk) {go_clear, go_set} <= 2'b00;
  endtask
  task automatic convert(input logic [2:0] d, input logic r,
      input logic [SEL_W-1:0] s, input logic x, input logic e);
    int cnt;
    int n;
    n = exp_len(d, r);
    strobes = 0;
    rnd();
    @(posedge sys_clk);
    // without irq enable the clear is held across finish: set must win
    {div, res, sel, xref, ie, gce} <= {d, r, s, x, e, 1'b1};
    ic <= ~e;
    level <= v[11:0];
    pulse(2'b01);
    @(posedge sys_clk) #1;
    cnt = 1;
    `CHK("go", 1'b1, go)
    `CHK("done", 1'b0, done)
    `CHK("ain", 10'h001 << s, ain)
    `CHK("conn", 1'b1, conn)
    `CHK("ext", x, ext)
    `CHK("pwr", 1'b1, pwr)
    while (done !== 1'b1 && cnt < n + 8) begin
      @(posedge sys_clk) #1;
      cnt++;
    end
    `CHK("len", n, cnt)
    `CHK("strobes", r ? 16 : 12, strobes)
    `CHK("go_end", 1'b0, go)
    `CHK("result", exp_res(level, s, r, x), result_buffer)
    `CHK("flag", 1'b1, flag)
    `CHK("irq", e, irq)
    @(posedge sys_clk) ic <= 1'b1;
    @(posedge sys_clk) ic <= 1'b0;
    #1 `CHK("flag_clr", 1'b0, flag)
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // the block sees only divider ticks, so this fast clock stands in
  // for a peripheral clock kept below the converter's limit
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (strobe === 1'b1) strobes++;
  end
  // ceiling covers warm-up plus the longest conversions with margin
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk) #1;
    `CHK("rst", 15'h0000, {go, done, flag, result_buffer})
    @(posedge sys_clk) en <= 1'b1;
    repeat (20000) @(posedge sys_clk);
    pulse(2'b01);
    repeat (3) @(posedge sys_clk) #1;
    `CHK("no_gce", 1'b0, go)
    convert(3'h0, 1'b0, 4'h0, 1'b0, 1'b1);
    convert(3'h0, 1'b1, 4'h9, 1'b1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      rnd();
      convert(3'(i), v[0], v[7:4] % 4'ha, v[1], v[2]);
    end
    pulse(2'b01);
    repeat (10) @(posedge sys_clk);
    en <= 1'b0;
    repeat (100) @(posedge sys_clk) #1;
    `CHK("frozen", 2'b10, {go, done})
    `CHK("pwr_off", 1'b0, pwr)
    @(posedge sys_clk) en <= 1'b1;
    pulse(2'b10);
    repeat (2) @(posedge sys_clk) #1;
    `CHK("abort", 2'b00, {go, done})
    // dropping global enable mid-run aborts like a go clear
    pulse(2'b01);
    repeat (5) @(posedge sys_clk);
    gce <= 1'b0;
    repeat (2) @(posedge sys_clk) #1;
    `CHK("gce_abort", 2'b00, {go, done})
    @(posedge sys_clk) {en, sel, gce} <= {1'b0, 4'ha, 1'b1};
    pulse(2'b01);
    repeat (3) @(posedge sys_clk) #1;
    `CHK("no_en", 1'b0, go)
    `CHK("bad_sel", 11'h000, {conn, ain})
    end_of_test();
  end
endmodule
`default_nettype wire
